// [rtl/sbs_port.sv]
// Sync burst static memory port: burst counter, read pipeline, deselect timing, APB mode control.
`timescale 1ns/100ps
`include "sbs_map.svh"
module sbs_port
    import sbs_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int LANE_W = 9,
    parameter int LANES  = 4
) (
    // Clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_b,
    // Synchronous memory bus
    input  wire sbs_cmd_t                i_cmd,
    input  wire logic [ADDR_W-1:0]       i_addr,
    input  wire logic [LANES*LANE_W-1:0] i_dq,
    output logic      [LANES*LANE_W-1:0] o_dq,
    output logic      [LANES*LANE_W-1:0] o_dq_oe,
    // Asynchronous controls
    input  wire logic                    i_out_en_n,
    input  wire logic                    i_sleep_req,
    // Mode pins
    input  wire logic                    i_flow_through_sel_n,
    input  wire logic                    i_linear_order_sel_n,
    input  wire logic                    i_deselect_depth_sel,
    // APB slave
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [31:0]             i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic      [31:0]             o_prdata,
    output logic                         o_pready,
    output logic                         o_pslverr
);

    localparam int DATA_W = LANES * LANE_W;

    // Pin synchronisers.
    logic       sleep_s1_reg, sleep_s2_reg;
    logic [2:0] mode_s1_reg, mode_s2_reg;
    // Burst state.
    sbs_state_t        state_reg, state_next;
    logic [ADDR_W-1:0] base_reg, base_next;
    logic [1:0]        start_reg, start_next;
    logic [1:0]        cnt_reg, cnt_next;
    // Input stage.
    sbs_op_t           s1_op_reg, s1_op_next;
    logic [ADDR_W-1:0] s1_addr_reg, s1_addr_next;
    logic              s1_desel_reg, s1_desel_next;
    logic [LANES-1:0]  s1_lane_reg, s1_lane_next;
    logic [DATA_W-1:0] s1_wdata_reg, s1_wdata_next;
    // Output stage.
    logic              s2_rd_reg, s2_rd_next;
    logic [DATA_W-1:0] s2_data_reg, s2_data_next;
    // APB registers.
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] prdata_reg, prdata_next;

    logic [DATA_W-1:0] rd_data;
    logic [1:0]        step_cnt;
    logic [1:0]        low_bits;
    logic              strobe;
    logic              wr_req;
    logic [LANES-1:0]  wr_lanes;
    logic              drive;
    logic              addr_hit;
    sbs_mode_t         mode;
    logic [31:0]       status;

    // Sleep and mode pins come from outside this clock, so each passes two flops first.
    always_ff @(posedge i_clk_sys) begin
        sleep_s1_reg <= i_sleep_req;
        sleep_s2_reg <= sleep_s1_reg;
        mode_s1_reg  <= {i_flow_through_sel_n, i_linear_order_sel_n, i_deselect_depth_sel};
        mode_s2_reg  <= mode_s1_reg;
    end

    // Register source is taken at reset, which gives the open-pin defaults.
    always_comb begin
        if (ctrl_reg[`SBS_CTRL_SRC_BIT]) begin
            mode.pipelined     = ctrl_reg[`SBS_CTRL_PIPE_BIT];
            mode.interleaved   = ctrl_reg[`SBS_CTRL_ILV_BIT];
            mode.dual_deselect = !ctrl_reg[`SBS_CTRL_SINGLE_BIT];
        end else begin
            mode.pipelined     = mode_s2_reg[2];
            mode.interleaved   = mode_s2_reg[1];
            mode.dual_deselect = !mode_s2_reg[0];
        end
    end

    // Write decode shared by strobe-started and continued cycles.
    always_comb begin
        wr_req = !i_cmd.global_write_n || !i_cmd.byte_write_en_n;
        if (!i_cmd.global_write_n) begin
            wr_lanes = '1;
        end else if (!i_cmd.byte_write_en_n) begin
            wr_lanes = ~i_cmd.lane_write_n[LANES-1:0];
        end else begin
            wr_lanes = '0;
        end
    end

    assign strobe   = !i_cmd.proc_addr_strobe_n || !i_cmd.ctrl_addr_strobe_n;
    assign step_cnt = cnt_reg + `SBS_CNT_ONE;
    // Counting wraps modulo four, so the fourth step returns to the start value.
    assign low_bits = mode.interleaved ? (start_reg ^ step_cnt)
                                       : (start_reg + step_cnt);

    // Burst and input stage next values; commands are taken at the clock edge, and none while synchronised sleep is high.
    always_comb begin
        state_next    = state_reg;
        base_next     = base_reg;
        start_next    = start_reg;
        cnt_next      = cnt_reg;
        s1_op_next    = SBS_OP_NONE;
        s1_addr_next  = s1_addr_reg;
        s1_desel_next = 1'b0;
        s1_lane_next  = '0;
        s1_wdata_next = i_dq;
        if (sleep_s2_reg) begin
            s1_op_next = SBS_OP_NONE;
        end else if (strobe && !i_cmd.chip_select_n) begin
            state_next   = SBS_ST_ACTIVE;
            base_next    = i_addr;
            start_next   = i_addr[`SBS_LOW_BITS-1:0];
            cnt_next     = `SBS_CNT_ZERO;
            s1_addr_next = i_addr;
            // A processor strobe always opens with a read; writes follow on later cycles.
            if (i_cmd.proc_addr_strobe_n && wr_req) begin
                s1_op_next   = SBS_OP_WRITE;
                s1_lane_next = wr_lanes;
            end else begin
                s1_op_next = SBS_OP_READ;
            end
        end else if (strobe) begin
            state_next    = SBS_ST_IDLE;
            s1_desel_next = 1'b1;
        end else if (state_reg == SBS_ST_ACTIVE) begin
            if (!i_cmd.burst_step_n) begin
                cnt_next = step_cnt;
                s1_addr_next = {base_reg[ADDR_W-1:`SBS_LOW_BITS], low_bits};
            end else begin
                s1_addr_next = {base_reg[ADDR_W-1:`SBS_LOW_BITS],
                                mode.interleaved ? (start_reg ^ cnt_reg)
                                                 : (start_reg + cnt_reg)};
            end
            if (wr_req) begin
                s1_op_next   = SBS_OP_WRITE;
                s1_lane_next = wr_lanes;
            end else begin
                s1_op_next = SBS_OP_READ;
            end
        end
        if (!i_rst_b) begin
            state_next = SBS_ST_IDLE;
            base_next  = '0;
            start_next = `SBS_CNT_ZERO;
            cnt_next   = `SBS_CNT_ZERO;
            s1_op_next = SBS_OP_NONE;
            s1_addr_next = '0;
            s1_desel_next = 1'b0;
            s1_lane_next  = '0;
            s1_wdata_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        state_reg    <= state_next;
        base_reg     <= base_next;
        start_reg    <= start_next;
        cnt_reg      <= cnt_next;
        s1_op_reg    <= s1_op_next;
        s1_addr_reg  <= s1_addr_next;
        s1_desel_reg <= s1_desel_next;
        s1_lane_reg  <= s1_lane_next;
        s1_wdata_reg <= s1_wdata_next;
    end

    // The array commits a captured write on the next edge by itself.
    sbs_mem_array #(
        .ADDR_W (ADDR_W),
        .LANE_W (LANE_W),
        .LANES  (LANES)
    ) u_array (
        .i_clk_sys (i_clk_sys),
        .i_wr_en   (s1_op_reg == SBS_OP_WRITE),
        .i_wr_lane (s1_lane_reg),
        .i_wr_addr (s1_addr_reg),
        .i_wr_data (s1_wdata_reg),
        .i_rd_addr (s1_addr_reg),
        .o_rd_data (rd_data)
    );

    // Output register stage used by pipelined reads.
    always_comb begin
        s2_rd_next   = (s1_op_reg == SBS_OP_READ);
        s2_data_next = (s1_op_reg == SBS_OP_READ) ? rd_data : s2_data_reg;
        if (!i_rst_b || sleep_s2_reg) begin
            s2_rd_next = 1'b0;
        end
        if (!i_rst_b) begin
            s2_data_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        s2_rd_reg   <= s2_rd_next;
        s2_data_reg <= s2_data_next;
    end

    // Pipelined drive lasts one stage past a deselect only in dual mode.
    always_comb begin
        if (mode.pipelined) begin
            drive = s2_rd_reg && (s1_op_reg != SBS_OP_WRITE)
                    && (mode.dual_deselect || !s1_desel_reg);
        end else begin
            drive = (s1_op_reg == SBS_OP_READ)
                    || (mode.dual_deselect && s1_desel_reg && s2_rd_reg);
        end
    end

    // Flow-through reads take the array output directly, trading cycle rate for latency.
    assign o_dq = (!mode.pipelined && s1_op_reg == SBS_OP_READ) ? rd_data : s2_data_reg;
    // Output enable gates the drivers without waiting for a clock edge.
    assign o_dq_oe = {DATA_W{drive && !i_out_en_n && !sleep_s2_reg}};

    // APB register file; reads are captured in the setup cycle so no wait is needed.
    assign addr_hit = (i_paddr[`SBS_ADDR_BITS-1:0] == `SBS_OFF_CTRL)
                   || (i_paddr[`SBS_ADDR_BITS-1:0] == `SBS_OFF_STATUS);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_hit;
    assign o_prdata  = prdata_reg;

    always_comb begin
        status = '0;
        status[`SBS_STAT_SLEEP_BIT]  = sleep_s2_reg;
        status[`SBS_STAT_ACTIVE_BIT] = (state_reg == SBS_ST_ACTIVE);
        status[`SBS_STAT_CNT_LSB +: 2] = cnt_reg;
        status[`SBS_STAT_DRIVE_BIT]  = drive;
    end

    always_comb begin
        ctrl_next   = ctrl_reg;
        prdata_next = prdata_reg;
        if (i_psel && !i_penable && !i_pwrite) begin
            if (i_paddr[`SBS_ADDR_BITS-1:0] == `SBS_OFF_CTRL) begin
                prdata_next = ctrl_reg;
            end else if (i_paddr[`SBS_ADDR_BITS-1:0] == `SBS_OFF_STATUS) begin
                prdata_next = status;
            end else begin
                prdata_next = '0;
            end
        end
        if (i_psel && i_penable && i_pwrite
            && i_paddr[`SBS_ADDR_BITS-1:0] == `SBS_OFF_CTRL) begin
            ctrl_next = i_pwdata & `SBS_CTRL_MASK;
        end
        if (!i_rst_b) begin
            ctrl_next   = `SBS_CTRL_RESET;
            prdata_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        ctrl_reg   <= ctrl_next;
        prdata_reg <= prdata_next;
    end

endmodule : sbs_port

// [inc/sbs_map.svh]
// Offsets, field positions, reset values and codes for the sync burst memory port.
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

`define SBS_OFF_CTRL         12'h000
`define SBS_OFF_STATUS       12'h004
`define SBS_ADDR_BITS        12

`define SBS_CTRL_SRC_BIT     0
`define SBS_CTRL_PIPE_BIT    1
`define SBS_CTRL_ILV_BIT     2
`define SBS_CTRL_SINGLE_BIT  3
`define SBS_CTRL_RESET       32'h0000000f
`define SBS_CTRL_MASK        32'h0000000f

`define SBS_STAT_SLEEP_BIT   0
`define SBS_STAT_ACTIVE_BIT  1
`define SBS_STAT_CNT_LSB     2
`define SBS_STAT_DRIVE_BIT   4

`define SBS_CNT_ZERO         2'h0
`define SBS_CNT_ONE          2'h1
`define SBS_LOW_BITS         2

`endif

// [inc/sbs_pkg.sv]
// Types shared by the sync burst memory port and its storage array.
package sbs_pkg;

    // Synchronous command pins, sampled on the rising clock edge.
    typedef struct packed {
        logic       proc_addr_strobe_n;
        logic       ctrl_addr_strobe_n;
        logic       burst_step_n;
        logic       chip_select_n;
        logic       global_write_n;
        logic       byte_write_en_n;
        logic [3:0] lane_write_n;
    } sbs_cmd_t;

    // Mode selection after pin and register sources are merged.
    typedef struct packed {
        logic pipelined;
        logic interleaved;
        logic dual_deselect;
    } sbs_mode_t;

    typedef enum logic [1:0] {
        SBS_OP_NONE  = 2'b00,
        SBS_OP_READ  = 2'b01,
        SBS_OP_WRITE = 2'b10
    } sbs_op_t;

    typedef enum logic [0:0] {
        SBS_ST_IDLE   = 1'b0,
        SBS_ST_ACTIVE = 1'b1
    } sbs_state_t;

endpackage : sbs_pkg

// [rtl/sbs_mem_array.sv]
// Byte-lane storage array with one write port and one combinational read port.
`timescale 1ns/100ps
module sbs_mem_array
    import sbs_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int LANE_W = 9,
    parameter int LANES  = 4
) (
    // Clock
    input  wire logic                    i_clk_sys,
    // Write port
    input  wire logic                    i_wr_en,
    input  wire logic [LANES-1:0]        i_wr_lane,
    input  wire logic [ADDR_W-1:0]       i_wr_addr,
    input  wire logic [LANES*LANE_W-1:0] i_wr_data,
    // Read port
    input  wire logic [ADDR_W-1:0]       i_rd_addr,
    output logic      [LANES*LANE_W-1:0] o_rd_data
);

    // Contents carry no reset, so they survive sleep and a stopped clock.
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] mem [2**ADDR_W];

        always_ff @(posedge i_clk_sys) begin
            if (i_wr_en && i_wr_lane[g]) begin
                mem[i_wr_addr] <= i_wr_data[g*LANE_W +: LANE_W];
            end
        end

        assign o_rd_data[g*LANE_W +: LANE_W] = mem[i_rd_addr];
    end

endmodule : sbs_mem_array

// [tb/sbs_port_monitor.sv]
// Checker for the pins of the sync burst memory port.
`timescale 1ns/100ps
module sbs_port_monitor
    import sbs_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int LANE_W = 9,
    parameter int LANES  = 4
) (
    // Clock and reset
    input wire logic                    i_clk_sys,
    input wire logic                    i_rst_b,
    // Memory bus
    input wire sbs_cmd_t                i_cmd,
    input wire logic [LANES*LANE_W-1:0] o_dq_oe,
    input wire logic                    i_out_en_n,
    input wire logic                    i_sleep_req,
    // APB
    input wire logic                    i_psel,
    input wire logic                    i_penable,
    input wire logic [31:0]             i_paddr,
    input wire logic                    o_pready,
    input wire logic                    o_pslverr
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    logic no_strobe;
    logic rd_take;
    logic wr_take;
    logic de_take;
    logic quiet;
    assign no_strobe = i_cmd.proc_addr_strobe_n && i_cmd.ctrl_addr_strobe_n;
    assign rd_take = !i_cmd.proc_addr_strobe_n && !i_cmd.chip_select_n;
    assign wr_take = i_cmd.proc_addr_strobe_n && !i_cmd.ctrl_addr_strobe_n
        && !i_cmd.chip_select_n && !(i_cmd.global_write_n && i_cmd.byte_write_en_n);
    assign de_take = !no_strobe && i_cmd.chip_select_n;
    // A quiet cycle continues a read burst with nothing to switch the drive off.
    assign quiet = no_strobe && !i_out_en_n && !i_sleep_req
        && i_cmd.global_write_n && i_cmd.byte_write_en_n;

    a_oe_gate: assert property (i_out_en_n |-> o_dq_oe == '0)
        else $error("data driven while output enable is off");
    a_lane_uniform: assert property (o_dq_oe == '0 || o_dq_oe == '1)
        else $error("byte lanes disagree on drive");
    a_write_float: assert property (wr_take |=> o_dq_oe == '0)
        else $error("data driven during a write");
    a_read_drive: assert property ((!i_sleep_req)[*3] ##0 rd_take ##1 quiet[*2] |-> o_dq_oe == '1)
        else $error("read data not driven within two edges");
    a_deselect_off: assert property (de_take ##1 no_strobe[*2] |-> o_dq_oe == '0)
        else $error("drive still on after deselect");
    a_sleep_off: assert property (i_sleep_req[*4] |-> o_dq_oe == '0)
        else $error("drive on during sleep");
    a_unmapped_err: assert property (i_psel && i_penable && i_paddr[31:12] == '0
        && i_paddr[11:3] != '0 |-> o_pslverr)
        else $error("unmapped access without error");
    a_ready_nowait: assert property (i_psel && i_penable |-> o_pready)
        else $error("access phase stalled");

    c_read: cover property (rd_take ##1 quiet);
    c_write: cover property (wr_take);
    c_desel: cover property (de_take ##1 no_strobe);
endmodule : sbs_port_monitor

// [tb/sbs_ctrl_model.sv]
// Controller model that drives the synchronous memory bus.
`timescale 1ns/100ps
module sbs_ctrl_model
    import sbs_pkg::*;
(
    // Clock
    input  wire logic  i_clk_sys,
    // Memory bus
    output sbs_cmd_t    o_cmd,
    output logic [20:0] o_addr,
    output logic [35:0] o_dq
);
    initial begin
        o_cmd  = sbs_cmd_t'(10'h3ff);
        o_addr = 21'h000000;
        o_dq   = 36'h000000000;
    end
    // One command per rising edge, no separate write strobe timing.
    task automatic put(input sbs_cmd_t c, input logic [20:0] a, input logic [35:0] d);
        @(posedge i_clk_sys);
        o_cmd  <= c;
        o_addr <= a;
        // A released data bus toggles, so a stale word can never pass a read.
        o_dq   <= (!c.global_write_n || !c.byte_write_en_n) ? d : ~o_dq;
    endtask : put
endmodule : sbs_ctrl_model

// [tb/sbs_port_test.sv]
// Testbench for the sync burst memory port.
`timescale 1ns/100ps
module sbs_port_test
    import sbs_pkg::*;
;
    localparam sbs_cmd_t C_RD   = sbs_cmd_t'(10'h1bf);
    localparam sbs_cmd_t C_STEP = sbs_cmd_t'(10'h33f);
    localparam sbs_cmd_t C_DES  = sbs_cmd_t'(10'h2ff);
    localparam sbs_cmd_t C_NOP  = sbs_cmd_t'(10'h3ff);
    localparam sbs_cmd_t C_GW   = sbs_cmd_t'(10'h29f);
    localparam sbs_cmd_t C_LN0  = sbs_cmd_t'(10'h2ae);
    logic        i_clk_sys            = 1'b0;
    logic        i_rst_b              = 1'b0;
    logic        i_out_en_n           = 1'b0;
    logic        i_sleep_req          = 1'b0;
    logic        i_flow_through_sel_n = 1'b1;
    logic        i_linear_order_sel_n = 1'b1;
    logic        i_deselect_depth_sel = 1'b1;
    logic        i_psel               = 1'b0;
    logic        i_penable            = 1'b0;
    logic        i_pwrite             = 1'b0;
    logic [31:0] i_paddr              = 32'h00000000;
    logic [31:0] i_pwdata             = 32'h00000000;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    sbs_cmd_t    i_cmd;
    logic [20:0] i_addr;
    logic [35:0] i_dq;
    logic [35:0] o_dq;
    logic [35:0] o_dq_oe;
    logic [35:0] mem [4];
    logic [31:0] rdata;
    logic        err;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #10 i_clk_sys = ~i_clk_sys;

    sbs_ctrl_model partner_u (.i_clk_sys(i_clk_sys), .o_cmd(i_cmd), .o_addr(i_addr), .o_dq(i_dq));
    sbs_port dut_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cmd(i_cmd), .i_addr(i_addr),
        .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_out_en_n(i_out_en_n),
        .i_sleep_req(i_sleep_req), .i_flow_through_sel_n(i_flow_through_sel_n),
        .i_linear_order_sel_n(i_linear_order_sel_n), .i_deselect_depth_sel(i_deselect_depth_sel),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_psel   <= 1'b1;
        i_pwrite <= wr;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rdata = o_prdata;
        err   = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic t_regs;
        apb(1'b0, 32'h00000000, 32'h00000000);
        chk(36'(rdata), 36'h00000000f);
        apb(1'b1, 32'h00000008, 32'hffffffff);
        chk(36'(err), 36'h000000001);
        $display("registers done");
    endtask : t_regs

    task automatic t_mode(input logic [31:0] v, input logic lin_n, input logic ft_n);
        @(posedge i_clk_sys);
        i_linear_order_sel_n <= lin_n;
        i_flow_through_sel_n <= ft_n;
        i_deselect_depth_sel <= 1'b0;
        apb(1'b1, 32'h00000000, v);
        apb(1'b0, 32'h00000000, 32'h00000000);
        chk(36'(rdata), 36'(v));
        repeat (3) @(posedge i_clk_sys);
        $display("mode done");
    endtask : t_mode

    task automatic t_store;
        for (int i = 0; i < 4; i++) begin
            mem[i] = 36'h5a5a5a500 | 36'(i);
            partner_u.put(C_GW, {19'h00040, 2'(i)}, mem[i]);
        end
        mem[2] = {mem[2][35:9], 9'h1c3};
        partner_u.put(C_LN0, 21'h000102, 36'hfffffffc3);
        partner_u.put(C_NOP, 21'h000000, 36'h000000000);
        @(negedge i_clk_sys);
        chk(o_dq_oe, 36'h000000000);
        $display("store done");
    endtask : t_store

    task automatic t_burst(input logic [1:0] s, input int n, input bit ilv, input bit ft,
                           input bit dual);
        logic [1:0] k;
        partner_u.put(C_RD, {19'h00040, s}, 36'h000000000);
        for (int i = 0; i <= n; i++) begin
            partner_u.put(i < n ? C_STEP : C_DES, 21'h000000, 36'h000000000);
            @(negedge i_clk_sys);
            k = ft ? 2'(i) : 2'(i - 1);
            if (ft ? i < n : i > 0) begin
                chk(o_dq, mem[ilv ? s ^ k : s + k]);
                chk(o_dq_oe, 36'hfffffffff);
            end
        end
        partner_u.put(C_NOP, 21'h000000, 36'h000000000);
        @(negedge i_clk_sys);
        chk(o_dq_oe, dual ? 36'hfffffffff : 36'h000000000);
        $display("burst done");
    endtask : t_burst

    task automatic t_sleep;
        @(posedge i_clk_sys);
        i_sleep_req <= 1'b1;
        repeat (5) partner_u.put(C_RD, 21'h000100, 36'h000000000);
        @(negedge i_clk_sys);
        chk(o_dq_oe, 36'h000000000);
        apb(1'b0, 32'h00000004, 32'h00000000);
        chk(36'(rdata[0]), 36'h000000001);
        @(posedge i_clk_sys);
        i_sleep_req <= 1'b0;
        partner_u.put(C_NOP, 21'h000000, 36'h000000000);
        repeat (3) @(posedge i_clk_sys);
        t_burst(2'h0, 1, 1'b1, 1'b1, 1'b1);
        partner_u.put(C_RD, 21'h000101, 36'h000000000);
        partner_u.put(C_NOP, 21'h000000, 36'h000000000);
        @(negedge i_clk_sys);
        chk(o_dq_oe, 36'hfffffffff);
        // No edge passes between raising the enable and the check, so only the gate can act.
        @(posedge i_clk_sys);
        i_out_en_n <= 1'b1;
        #1 chk(o_dq_oe, 36'h000000000);
        @(posedge i_clk_sys);
        i_out_en_n <= 1'b0;
        partner_u.put(C_DES, 21'h000000, 36'h000000000);
        partner_u.put(C_NOP, 21'h000000, 36'h000000000);
        $display("sleep done");
    endtask : t_sleep

    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        t_regs();
        t_store();
        t_burst(2'h1, 5, 1'b1, 1'b0, 1'b0);
        t_mode(32'h00000000, 1'b0, 1'b0);
        t_burst(2'h2, 5, 1'b0, 1'b1, 1'b1);
        t_mode(32'h00000005, 1'b1, 1'b1);
        t_burst(2'h3, 4, 1'b1, 1'b1, 1'b1);
        t_sleep();
        final_report();
    end
endmodule : sbs_port_test

bind sbs_port sbs_port_monitor #(.ADDR_W(ADDR_W), .LANE_W(LANE_W), .LANES(LANES)) mon_u (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cmd(i_cmd), .o_dq_oe(o_dq_oe),
    .i_out_en_n(i_out_en_n), .i_sleep_req(i_sleep_req), .i_psel(i_psel),
    .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr));
